// ---- pkg/frm_pkg.sv ----
// Summary of operation
// - count every valid frame observed while listening in redundancy mode
// - count every valid frame sourced by our own station address while listening in redundancy mode
// - after takeover, count each bus time-out seen while active
// - time-out interval is (6 + 2 * station address) slot times
// - stay passive; drive the bus only from the takeover start flag until the stop completes
// - finish bus start-up within ten minimum slave intervals of the start flag
// - on start flag clear, leave the bus at the next token transmission once active, at once during start-up
// - stop happens at cycle end, at the latest after the estimated cycle time
// - keep slave connections on stop, whatever the release setting says
// - no process data image updates while only listening
package frm_pkg;
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          US_NS         = 1000;
  localparam logic [15:0] US_DIV        = 16'(US_NS / CLK_PERIOD_NS);
  localparam int          TMR_W         = 26;
  localparam int          CNT_W         = 16;

  localparam logic [3:0] REG_CTRL          = 4'h0;
  localparam logic [3:0] REG_STATION       = 4'h1;
  localparam logic [3:0] REG_VALID_COUNT   = 4'h2;
  localparam logic [3:0] REG_PRIMARY_COUNT = 4'h3;
  localparam logic [3:0] REG_TIMEOUT_COUNT = 4'h4;
  localparam logic [3:0] REG_SLOT_TIME     = 4'h5;
  localparam logic [3:0] REG_MIN_SLAVE_US  = 4'h6;
  localparam logic [3:0] REG_EST_CYCLE_US  = 4'h7;
  localparam logic [3:0] REG_BIT_DIV       = 4'h8;
  localparam logic [3:0] REG_IRQ_STATUS    = 4'h9;
  localparam logic [3:0] REG_IRQ_CLEAR     = 4'ha;
  localparam logic [3:0] REG_IRQ_ENABLE    = 4'hb;
  localparam logic [3:0] REG_STATE         = 4'hc;

  localparam int CTRL_START   = 0;
  localparam int CTRL_REDUND  = 1;
  localparam int CTRL_RELEASE = 2;

  localparam int EV_W       = 5;
  localparam int EV_FRAME   = 0;
  localparam int EV_PRIMARY = 1;
  localparam int EV_TIMEOUT = 2;
  localparam int EV_RUNNING = 3;
  localparam int EV_STOPPED = 4;

  localparam logic [2:0]  RST_CTRL      = 3'h2;
  localparam logic [6:0]  RST_STATION   = 7'h01;
  localparam logic [15:0] RST_SLOT_TIME = 16'h0064;
  localparam logic [15:0] RST_MIN_SLAVE = 16'h0064;
  localparam logic [15:0] RST_EST_CYCLE = 16'h03e8;
  localparam logic [15:0] RST_BIT_DIV   = 16'h0008;

  localparam int CLAIM_BASE   = 6;
  localparam int CLAIM_MULT   = 2;
  localparam int STARTUP_MULT = 10;

  typedef enum logic [3:0] {
    ST_LISTEN = 4'b0001,
    ST_START  = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_STOP   = 4'b1000
  } frm_state_e;

  function automatic logic [TMR_W-1:0] claim_timeout(input logic [6:0] addr,
                                                      input logic [15:0] slot);
    claim_timeout = TMR_W'((CLAIM_BASE + CLAIM_MULT * int'(addr)) * int'(slot));
  endfunction : claim_timeout

  function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] v);
    wrap_inc = v + CNT_W'(1);
  endfunction : wrap_inc
endpackage : frm_pkg

// ---- design/frm_tick_div.sv ----
`timescale 1ns/1ps
module frm_tick_div (
  input  wire logic        clock,   // system clock
  input  wire logic        arst_n,  // async reset
  input  wire logic [15:0] div,     // cycles per tick
  output logic             tick     // one-cycle enable
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } frm_div_s;

  frm_div_s s, next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (s.cnt + 16'h0001 >= div) begin
      next_s.cnt  = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) s <= '0;
    else s <= next_s;
  end

  assign tick = s.tick;
endmodule : frm_tick_div

// ---- design/frm_timer.sv ----
`timescale 1ns/1ps
module frm_timer (
  input  wire logic                    clock,     // system clock
  input  wire logic                    arst_n,    // async reset
  input  wire logic                    load,      // start with load_val
  input  wire logic                    clear,     // abandon count
  input  wire logic [frm_pkg::TMR_W-1:0] load_val,  // ticks to run
  input  wire logic                    tick,      // count enable
  output logic                         expired,   // one-cycle pulse
  output logic                         running    // level
);
  typedef struct packed {
    logic [frm_pkg::TMR_W-1:0] cnt;
    logic                      run;
    logic                      exp;
  } frm_tmr_s;

  frm_tmr_s s, next_s;

  always_comb begin
    next_s     = s;
    next_s.exp = 1'b0;
    if (clear) begin
      next_s.run = 1'b0;
    end else if (load) begin
      next_s.cnt = load_val;
      next_s.run = 1'b1;
    end else if (s.run && tick) begin
      // zero load expires on the first tick
      if (s.cnt <= frm_pkg::TMR_W'(1)) begin
        next_s.run = 1'b0;
        next_s.exp = 1'b1;
      end else begin
        next_s.cnt = s.cnt - frm_pkg::TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) s <= '0;
    else s <= next_s;
  end

  assign expired = s.exp;
  assign running = s.run;
endmodule : frm_timer

// ---- design/frm_redundancy_master.sv ----
`timescale 1ns/1ps
module frm_redundancy_master (
  input  wire logic        clock,                // 40 MHz system clock
  input  wire logic        arst_n,               // async reset, active low
  input  wire logic [3:0]  reg_addr,             // register index
  input  wire logic [15:0] reg_wdata,            // write data
  input  wire logic        reg_wr,               // write strobe
  input  wire logic        reg_rd,               // read strobe
  output logic      [15:0] reg_rdata,            // read data, cycle after strobe
  output logic             irq,                  // level interrupt
  input  wire logic        frame_valid,          // pulse: valid frame decoded
  input  wire logic [6:0]  frame_src_addr,       // source address of that frame
  input  wire logic        rx_busy,              // receiver sees line activity
  input  wire logic        token_sent,           // pulse: our token pass done
  output logic             master_tx_enable,     // may drive the bus
  output logic             image_update_enable,  // may refresh process images
  output logic             slave_link_hold       // slaves kept locked after stop
);
  typedef struct packed {
    logic [2:0]               ctrl;
    logic [6:0]               station;
    logic [15:0]              slot_time;
    logic [15:0]              min_slave_us;
    logic [15:0]              est_cycle_us;
    logic [15:0]              bit_div;
    logic [frm_pkg::CNT_W-1:0] valid_frame_count;
    logic [frm_pkg::CNT_W-1:0] primary_frame_count;
    logic [frm_pkg::CNT_W-1:0] token_claim_timeout_count;
    logic [frm_pkg::EV_W-1:0]  irq_status;
    logic [frm_pkg::EV_W-1:0]  irq_enable;
    logic [15:0]              rdata;
    frm_pkg::frm_state_e      state;
    logic                     link_hold;
  } frm_top_s;

  frm_top_s s, next_s;

  logic                      us_tick;
  logic                      bit_tick;
  logic                      phase_load;
  logic [frm_pkg::TMR_W-1:0] phase_val;
  logic                      phase_exp;
  logic                      phase_run;
  logic                      tmo_load;
  logic                      tmo_clear;
  logic [frm_pkg::TMR_W-1:0] tmo_val;
  logic                      tmo_exp;
  logic                      listening;
  logic                      takeover_start_flag;
  logic                      redundancy_mode;
  logic [frm_pkg::EV_W-1:0]  events;
  logic [frm_pkg::EV_W-1:0]  clear_mask;

  frm_tick_div u_us_div (
    .clock  (clock),
    .arst_n (arst_n),
    .div    (frm_pkg::US_DIV),
    .tick   (us_tick)
  );

  // bit time base, slot time counts in bit times
  frm_tick_div u_bit_div (
    .clock  (clock),
    .arst_n (arst_n),
    .div    (s.bit_div),
    .tick   (bit_tick)
  );

  frm_timer u_phase (
    .clock    (clock),
    .arst_n   (arst_n),
    .load     (phase_load),
    .clear    (1'b0),
    .load_val (phase_val),
    .tick     (us_tick),
    .expired  (phase_exp),
    .running  (phase_run)
  );

  frm_timer u_claim (
    .clock    (clock),
    .arst_n   (arst_n),
    .load     (tmo_load),
    .clear    (tmo_clear),
    .load_val (tmo_val),
    .tick     (bit_tick),
    .expired  (tmo_exp),
    .running  ()
  );

  assign takeover_start_flag = s.ctrl[frm_pkg::CTRL_START];
  assign redundancy_mode     = s.ctrl[frm_pkg::CTRL_REDUND];
  assign listening           = redundancy_mode && (s.state == frm_pkg::ST_LISTEN);

  assign tmo_val   = frm_pkg::claim_timeout(s.station, s.slot_time);
  // any line activity proves a live token holder, so restart the wait
  assign tmo_load  = (next_s.state == frm_pkg::ST_ACTIVE) &&
                     ((s.state != frm_pkg::ST_ACTIVE) || rx_busy || frame_valid || tmo_exp);
  assign tmo_clear = (next_s.state != frm_pkg::ST_ACTIVE);

  assign clear_mask = (reg_wr && reg_addr == frm_pkg::REG_IRQ_CLEAR) ?
                      reg_wdata[frm_pkg::EV_W-1:0] : '0;

  always_comb begin
    next_s     = s;
    phase_load = 1'b0;
    phase_val  = '0;
    events     = '0;
    next_s.rdata = 16'h0000;

    unique case (s.state)
      frm_pkg::ST_LISTEN: begin
        if (takeover_start_flag) begin
          next_s.state = frm_pkg::ST_START;
          phase_load   = 1'b1;
          phase_val    = frm_pkg::TMR_W'(frm_pkg::STARTUP_MULT * int'(s.min_slave_us));
        end
      end
      frm_pkg::ST_START: begin
        if (!takeover_start_flag) begin
          next_s.state = frm_pkg::ST_LISTEN;
        end else if (phase_exp) begin
          next_s.state     = frm_pkg::ST_ACTIVE;
          next_s.link_hold = 1'b0;
          events[frm_pkg::EV_RUNNING] = 1'b1;
        end
      end
      frm_pkg::ST_ACTIVE: begin
        if (!takeover_start_flag) begin
          // no abrupt cut: finish the cycle, leave with the token
          next_s.state = frm_pkg::ST_STOP;
          phase_load   = 1'b1;
          phase_val    = frm_pkg::TMR_W'(s.est_cycle_us);
        end
      end
      frm_pkg::ST_STOP: begin
        if (token_sent || phase_exp) begin
          next_s.state     = frm_pkg::ST_LISTEN;
          // release setting ignored here on purpose
          next_s.link_hold = 1'b1;
          events[frm_pkg::EV_STOPPED] = 1'b1;
        end else if (takeover_start_flag) begin
          next_s.state = frm_pkg::ST_ACTIVE;
        end
      end
    endcase

    if (frame_valid && listening) begin
      next_s.valid_frame_count = frm_pkg::wrap_inc(s.valid_frame_count);
      events[frm_pkg::EV_FRAME] = 1'b1;
      if (frame_src_addr == s.station) begin
        next_s.primary_frame_count = frm_pkg::wrap_inc(s.primary_frame_count);
        events[frm_pkg::EV_PRIMARY] = 1'b1;
      end
    end
    if (tmo_exp && s.state == frm_pkg::ST_ACTIVE) begin
      next_s.token_claim_timeout_count = frm_pkg::wrap_inc(s.token_claim_timeout_count);
      events[frm_pkg::EV_TIMEOUT] = 1'b1;
    end

    if (reg_wr) begin
      unique case (reg_addr)
        frm_pkg::REG_CTRL:         next_s.ctrl         = reg_wdata[2:0];
        frm_pkg::REG_STATION:      next_s.station      = reg_wdata[6:0];
        frm_pkg::REG_SLOT_TIME:    next_s.slot_time    = reg_wdata;
        frm_pkg::REG_MIN_SLAVE_US: next_s.min_slave_us = reg_wdata;
        frm_pkg::REG_EST_CYCLE_US: next_s.est_cycle_us = reg_wdata;
        frm_pkg::REG_BIT_DIV:      next_s.bit_div      = reg_wdata;
        frm_pkg::REG_IRQ_ENABLE:   next_s.irq_enable   = reg_wdata[frm_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    next_s.irq_status = (s.irq_status & ~clear_mask) | events;

    if (reg_rd) begin
      unique case (reg_addr)
        frm_pkg::REG_CTRL:          next_s.rdata = {13'h0000, s.ctrl};
        frm_pkg::REG_STATION:       next_s.rdata = {9'h000, s.station};
        frm_pkg::REG_VALID_COUNT:   next_s.rdata = s.valid_frame_count;
        frm_pkg::REG_PRIMARY_COUNT: next_s.rdata = s.primary_frame_count;
        frm_pkg::REG_TIMEOUT_COUNT: next_s.rdata = s.token_claim_timeout_count;
        frm_pkg::REG_SLOT_TIME:     next_s.rdata = s.slot_time;
        frm_pkg::REG_MIN_SLAVE_US:  next_s.rdata = s.min_slave_us;
        frm_pkg::REG_EST_CYCLE_US:  next_s.rdata = s.est_cycle_us;
        frm_pkg::REG_BIT_DIV:       next_s.rdata = s.bit_div;
        frm_pkg::REG_IRQ_STATUS:    next_s.rdata = {11'h000, s.irq_status};
        frm_pkg::REG_IRQ_ENABLE:    next_s.rdata = {11'h000, s.irq_enable};
        frm_pkg::REG_STATE:         next_s.rdata = {11'h000, s.link_hold, s.state};
        default:                    next_s.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s                           <= '0;
      s.ctrl                      <= frm_pkg::RST_CTRL;
      s.station                   <= frm_pkg::RST_STATION;
      s.slot_time                 <= frm_pkg::RST_SLOT_TIME;
      s.min_slave_us              <= frm_pkg::RST_MIN_SLAVE;
      s.est_cycle_us              <= frm_pkg::RST_EST_CYCLE;
      s.bit_div                   <= frm_pkg::RST_BIT_DIV;
      s.state                     <= frm_pkg::ST_LISTEN;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata           = s.rdata;
  assign irq                 = |(s.irq_status & s.irq_enable);
  assign master_tx_enable    = (s.state != frm_pkg::ST_LISTEN);
  assign image_update_enable = (s.state == frm_pkg::ST_ACTIVE) ||
                               (s.state == frm_pkg::ST_STOP);
  assign slave_link_hold     = s.link_hold;

  chk_valid_count: assert property (@(posedge clock) disable iff (!arst_n)
    frame_valid && listening |=> s.valid_frame_count == $past(s.valid_frame_count) + 16'h0001)
    else $error("valid frame count missed a frame");

  chk_primary_count: assert property (@(posedge clock) disable iff (!arst_n)
    frame_valid && listening && frame_src_addr != s.station
    |=> s.primary_frame_count == $past(s.primary_frame_count))
    else $error("primary count moved on a foreign frame");

  chk_timeout_count: assert property (@(posedge clock) disable iff (!arst_n)
    tmo_exp && s.state == frm_pkg::ST_ACTIVE
    |=> s.token_claim_timeout_count == $past(s.token_claim_timeout_count) + 16'h0001)
    else $error("claim timeout not counted");

  chk_claim_interval: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_START ##1 s.state == frm_pkg::ST_ACTIVE
    |-> int'(u_claim.s.cnt) == (6 + 2 * int'(s.station)) * int'(s.slot_time))
    else $error("claim timer loaded with wrong interval");

  chk_passive_quiet: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_LISTEN && !takeover_start_flag |=> !master_tx_enable)
    else $error("bus driven without start flag");

  chk_start_timer: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_LISTEN && takeover_start_flag
    |=> s.state == frm_pkg::ST_START && phase_run &&
        int'(u_phase.s.cnt) == 10 * int'(s.min_slave_us))
    else $error("start-up bound not armed");

  chk_stop_token: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_STOP && token_sent |=> s.state == frm_pkg::ST_LISTEN)
    else $error("stop did not follow token pass");

  chk_stop_bound: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_STOP && phase_exp |=> !master_tx_enable)
    else $error("stop overran estimated cycle time");

  chk_link_kept: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_STOP ##1 s.state == frm_pkg::ST_LISTEN |-> slave_link_hold)
    else $error("slave links dropped at stop");

  chk_no_image: assert property (@(posedge clock) disable iff (!arst_n)
    (s.state == frm_pkg::ST_LISTEN || s.state == frm_pkg::ST_START) |-> !image_update_enable)
    else $error("process image updated while listening");

  chk_count_wrap: assert property (@(posedge clock) disable iff (!arst_n)
    frame_valid && listening && s.valid_frame_count == 16'hffff
    |=> s.valid_frame_count == 16'h0000)
    else $error("frame counter saturated");

  // frames outside listening must leave the counter alone, not just the status
  chk_listen_no_count: assert property (@(posedge clock) disable iff (!arst_n)
    frame_valid && !listening |=> s.valid_frame_count == $past(s.valid_frame_count))
    else $error("frame counted outside listening");

  chk_primary_inc: assert property (@(posedge clock) disable iff (!arst_n)
    frame_valid && listening && frame_src_addr == s.station
    |=> s.primary_frame_count == $past(s.primary_frame_count) + 16'h0001)
    else $error("own address frame not counted");

  chk_start_abandon: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_START && !takeover_start_flag
    |=> s.state == frm_pkg::ST_LISTEN && !master_tx_enable)
    else $error("abandoned start kept the bus");

  chk_stop_deferred: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_ACTIVE && !takeover_start_flag
    |=> s.state == frm_pkg::ST_STOP && master_tx_enable)
    else $error("bus dropped before token pass");

  // timer peeks rely on a load beating a tick on the same edge
  chk_stop_armed: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_ACTIVE && !takeover_start_flag
    |=> phase_run && int'(u_phase.s.cnt) == int'($past(s.est_cycle_us)))
    else $error("cycle time bound not armed");

  chk_claim_reload: assert property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_ACTIVE && takeover_start_flag && rx_busy
    |=> int'(u_claim.s.cnt) == (6 + 2 * int'($past(s.station))) * int'($past(s.slot_time)))
    else $error("line activity did not restart claim wait");

  chk_image_entry: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(image_update_enable) |-> $past(s.state) == frm_pkg::ST_START)
    else $error("process image enabled without start-up");

  chk_event_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    |events |=> (s.irq_status & $past(events)) == $past(events))
    else $error("event lost against a status clear");

  cov_takeover: cover property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_START ##1 s.state == frm_pkg::ST_ACTIVE);
  cov_token_stop: cover property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_STOP && token_sent);
  cov_claim_timeout: cover property (@(posedge clock) disable iff (!arst_n)
    tmo_exp && s.state == frm_pkg::ST_ACTIVE);
  cov_primary_frame: cover property (@(posedge clock) disable iff (!arst_n)
    frame_valid && listening && frame_src_addr == s.station);
  cov_stop_timeout: cover property (@(posedge clock) disable iff (!arst_n)
    s.state == frm_pkg::ST_STOP && phase_exp);
endmodule : frm_redundancy_master

// ---- testbench/frm_bus_model.sv ----
`timescale 1ns/1ps
module frm_bus_model (
  input  wire logic       clock,          // system clock
  input  wire logic       arst_n,         // async reset, active low
  input  wire logic       send_frame,     // put one valid frame on the bus
  input  wire logic [6:0] send_src,       // source address of that frame
  input  wire logic       send_token,     // token pass finished
  input  wire logic       line_busy,      // line activity without a frame
  output logic            frame_valid,    // decoded frame pulse
  output logic      [6:0] frame_src_addr, // source address, valid with frame
  output logic            rx_busy,        // activity level
  output logic            token_sent      // token pass pulse
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      frame_valid    <= 1'b0;
      frame_src_addr <= 7'h00;
      rx_busy        <= 1'b0;
      token_sent     <= 1'b0;
    end else begin
      frame_valid    <= send_frame;
      // address is not held between frames, so flip it on every idle cycle
      frame_src_addr <= send_frame ? send_src : ~frame_src_addr;
      rx_busy        <= line_busy | send_frame;
      token_sent     <= send_token;
    end
  end
endmodule : frm_bus_model

// ---- testbench/fieldbus_redundancy_master_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module fieldbus_redundancy_master_test;
  logic        clock, arst_n, reg_wr, reg_rd, irq, frame_valid, rx_busy, token_sent;
  logic        master_tx_enable, image_update_enable, slave_link_hold;
  logic        send_frame, send_token, line_busy;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, n_valid, n_prim, n_to;
  logic [6:0]  frame_src_addr, send_src, station;
  logic [31:0] seed;
  int          n_fail, n_tests, n, tt;

  frm_redundancy_master i_frm_redundancy_master (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .frame_valid(frame_valid),
    .frame_src_addr(frame_src_addr), .rx_busy(rx_busy), .token_sent(token_sent),
    .master_tx_enable(master_tx_enable), .image_update_enable(image_update_enable),
    .slave_link_hold(slave_link_hold));
  frm_bus_model i_frm_bus_model (.clock(clock), .arst_n(arst_n), .send_frame(send_frame),
    .send_src(send_src), .send_token(send_token), .line_busy(line_busy),
    .frame_valid(frame_valid), .frame_src_addr(frame_src_addr), .rx_busy(rx_busy),
    .token_sent(token_sent));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  function automatic logic [15:0] rst_val(input logic [3:0] a);
    case (a)
      frm_pkg::REG_CTRL:         rst_val = 16'h0002;
      frm_pkg::REG_STATION:      rst_val = 16'h0001;
      frm_pkg::REG_SLOT_TIME:    rst_val = 16'h0064;
      frm_pkg::REG_MIN_SLAVE_US: rst_val = 16'h0064;
      frm_pkg::REG_EST_CYCLE_US: rst_val = 16'h03e8;
      frm_pkg::REG_BIT_DIV:      rst_val = 16'h0008;
      frm_pkg::REG_STATE:        rst_val = 16'h0001;
      default:                   rst_val = 16'h0000;
    endcase
  endfunction : rst_val

  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
    rd(a, d);
    `CHK(nm, e, d)
  endtask : rchk

  task wait_act;
    n = 0;
    while (image_update_enable !== 1'b1 && n < 1000) begin
      @(posedge clock);
      #1 n++;
    end
  endtask : wait_act

  task wrap_up;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (95000) @(posedge clock);
    n_fail++;
    wrap_up();
  end

  initial begin
    arst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
    send_frame = 1'b0; send_src = 7'h00; send_token = 1'b0; line_busy = 1'b0;
    seed = 32'd382; n_fail = 0; n_tests = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), d);
      `CHK("reset value", rst_val(4'(i)), d)
    end
    `CHK("tx idle", 1'b0, master_tx_enable)
    seed = xs(seed);
    station = 7'(seed % 20) + 7'h01;
    wr(frm_pkg::REG_STATION, {9'h000, station});
    wr(frm_pkg::REG_SLOT_TIME, 16'h0001);
    wr(frm_pkg::REG_MIN_SLAVE_US, 16'h0001);
    wr(frm_pkg::REG_BIT_DIV, 16'h0002);
    wr(frm_pkg::REG_EST_CYCLE_US, 16'h0014);
    wr(frm_pkg::REG_VALID_COUNT, 16'h1234);
    n_valid = 16'h0000;
    n_prim = 16'h0000;
    // random traffic, back-to-back frames, some from our own address
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      @(posedge clock);
      send_frame <= seed[0];
      send_src   <= seed[1] ? station : seed[8:2];
      n_valid += 16'(seed[0]);
      n_prim  += 16'(seed[0] && (seed[1] || seed[8:2] == station));
    end
    @(posedge clock);
    send_frame <= 1'b0;
    repeat (2) @(posedge clock);
    rchk("valid count", frm_pkg::REG_VALID_COUNT, n_valid);
    rchk("primary count", frm_pkg::REG_PRIMARY_COUNT, n_prim);
    `CHK("image listen", 1'b0, image_update_enable)
    `CHK("tx listen", 1'b0, master_tx_enable)
    wr(frm_pkg::REG_CTRL, 16'h0000);
    @(posedge clock);
    send_frame <= 1'b1;
    send_src   <= station;
    repeat (3) @(posedge clock);
    send_frame <= 1'b0;
    repeat (3) @(posedge clock);
    rchk("count redund off", frm_pkg::REG_VALID_COUNT, n_valid);
    wr(frm_pkg::REG_CTRL, 16'h0002);
    rchk("status", frm_pkg::REG_IRQ_STATUS, {14'h0000, n_prim != 0, n_valid != 0});
    wr(frm_pkg::REG_IRQ_ENABLE, 16'h0001);
    #1 `CHK("irq on", 1'b1, irq)
    wr(frm_pkg::REG_IRQ_ENABLE, 16'h0000);
    #1 `CHK("irq masked", 1'b0, irq)
    wr(frm_pkg::REG_IRQ_ENABLE, 16'h001f);
    wr(frm_pkg::REG_IRQ_CLEAR, 16'h001f);
    #1 `CHK("irq cleared", 1'b0, irq)
    rchk("clear reads zero", frm_pkg::REG_IRQ_CLEAR, 16'h0000);
    // full lap of the counter: it must wrap, not stick at the top
    @(posedge clock);
    send_frame <= 1'b1;
    send_src   <= station + 7'h01;
    repeat (65536) @(posedge clock);
    send_frame <= 1'b0;
    repeat (3) @(posedge clock);
    rchk("valid wrap", frm_pkg::REG_VALID_COUNT, n_valid);
    rchk("primary other src", frm_pkg::REG_PRIMARY_COUNT, n_prim);
    wr(frm_pkg::REG_CTRL, 16'h0003);
    wr(frm_pkg::REG_CTRL, 16'h0002);
    repeat (2) @(posedge clock);
    rchk("start abandoned", frm_pkg::REG_STATE, 16'h0001);
    wr(frm_pkg::REG_CTRL, 16'h0003);
    @(posedge clock);
    #1 `CHK("tx start", 1'b1, master_tx_enable)
    `CHK("image start", 1'b0, image_update_enable)
    wait_act();
    `CHK("startup time", 1'b1, (n >= 359 && n <= 420))
    rchk("link state current", frm_pkg::REG_STATE, {12'h000, frm_pkg::ST_ACTIVE});
    @(posedge clock);
    line_busy <= 1'b1;
    rd(frm_pkg::REG_TIMEOUT_COUNT, n_to);
    tt = 2 * (6 + 2 * int'(station));
    @(posedge clock);
    line_busy <= 1'b0;
    repeat (tt - 6) @(posedge clock);
    rchk("no timeout yet", frm_pkg::REG_TIMEOUT_COUNT, n_to);
    repeat (10) @(posedge clock);
    rchk("timeout counted", frm_pkg::REG_TIMEOUT_COUNT, n_to + 16'h0001);
    @(posedge clock);
    line_busy <= 1'b1;
    wr(frm_pkg::REG_CTRL, 16'h0006);
    repeat (20) @(posedge clock);
    #1 `CHK("tx until token", 1'b1, master_tx_enable)
    @(posedge clock);
    send_token <= 1'b1;
    @(posedge clock);
    send_token <= 1'b0;
    repeat (2) @(posedge clock);
    #1 `CHK("tx after token", 1'b0, master_tx_enable)
    `CHK("image stopped", 1'b0, image_update_enable)
    `CHK("link held", 1'b1, slave_link_hold)
    rchk("state stopped", frm_pkg::REG_STATE, 16'h0011);
    wr(frm_pkg::REG_EST_CYCLE_US, 16'h0002);
    wr(frm_pkg::REG_CTRL, 16'h0003);
    wait_act();
    `CHK("startup again", 1'b1, (n >= 359 && n <= 420))
    wr(frm_pkg::REG_CTRL, 16'h0002);
    repeat (35) @(posedge clock);
    #1 `CHK("tx cycle end", 1'b1, master_tx_enable)
    repeat (55) @(posedge clock);
    #1 `CHK("tx cycle limit", 1'b0, master_tx_enable)
    `CHK("link held again", 1'b1, slave_link_hold)
    rchk("status events", frm_pkg::REG_IRQ_STATUS, 16'h001d);
    wrap_up();
  end
endmodule : fieldbus_redundancy_master_test
